/* File: sim/pls_keypad.sv */
`timescale 1ns/10ps
`default_nettype none
module pls_keypad (
    // Clock.
    input  wire logic i_clk,
    // Keypad lines and reset contact.
    output logic      o_present = 1'b1,
    output logic      o_legacy = 1'b0,
    output logic      o_stop_key = 1'b0,
    output logic      o_contact = 1'b0
);
    // Pulls the keypad for n cycles, then seats it firmly again.
    task automatic unplug(input int n);
        o_present <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_present <= 1'b1;
    endtask
    task automatic set_stop(input logic v);
        o_stop_key <= v;
    endtask
    // Closes the reset contact for n cycles, then opens it.
    task automatic tap_reset(input int n);
        o_contact <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_contact <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: sim/pls_props.sv */
`timescale 1ns/10ps
`default_nettype none
module pls_props
    import pls_pkg::*;
(
    // Clock, reset and bus.
    input wire logic        I_CLK,
    input wire logic        I_RSTN,
    input wire logic        I_HSEL,
    input wire logic [7:0]  I_HADDR,
    input wire logic [1:0]  I_HTRANS,
    input wire logic        I_HWRITE,
    input wire logic [31:0] I_HWDATA,
    input wire logic        I_HREADY,
    input wire logic        O_HREADYOUT,
    input wire logic        O_HRESP,
    // Keypad side and outputs.
    input wire logic        I_KEYPAD_PRESENT,
    input wire logic        I_KEYPAD_LEGACY,
    input wire logic        I_STOP_KEY,
    input wire logic        I_KEYPAD_MODE,
    input wire logic        I_RESET_CONTACT,
    input wire pls_out_s    O_CTRL
);
    logic             wr_q;
    logic [4:0]       sel_q;
    logic             seen_q;
    logic [CNT_W-1:0] abs_q;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    // Shadow of the selection field, taken in the write data phase.
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            wr_q  <= 1'b0;
            sel_q <= SEL_RESET_VAL;
        end else if (I_HREADY) begin
            wr_q <= I_HSEL && I_HWRITE && I_HTRANS == HTRANS_NONSEQ
                    && I_HADDR == ADDR_CTRL;
            if (wr_q) begin
                sel_q <= I_HWDATA[4:0];
            end
        end
    end
    // Cycles of absence once the keypad has been seen.
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            seen_q <= 1'b0;
            abs_q  <= '0;
        end else begin
            seen_q <= seen_q || I_KEYPAD_PRESENT;
            if (I_KEYPAD_PRESENT || !seen_q) begin
                abs_q <= '0;
            end else if (abs_q != '1) begin
                abs_q <= abs_q + 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    decel_a: assert property ($past(I_RSTN) |-> O_CTRL.decel_stop ==
        $past(I_STOP_KEY && (I_KEYPAD_MODE || sel_q >= 5'h0e)))
        else $error("stop key decel mismatch");
    early_loss_a: assert property ($rose(O_CTRL.alarm_stop) |->
        seen_q && $past(abs_q, 2) >= LOSS_CYCLES - 1)
        else $error("loss alarm too early");
    alarm_show_a: assert property (O_CTRL.alarm_stop |->
        O_CTRL.output_off && O_CTRL.disconnect_msg)
        else $error("alarm without indication");
    sel_loss_a: assert property ($rose(O_CTRL.alarm_stop) |->
        $past(sel_q, 2) inside {5'h02, 5'h03, 5'h10, 5'h11})
        else $error("alarm with detection off");
    legacy_code_a: assert property ($rose(O_CTRL.alarm_stop) |->
        O_CTRL.led_code == ($past(I_KEYPAD_LEGACY, 2) ?
        LEGACY_LOSS_CODE : KEYPAD_LOSS_CODE))
        else $error("wrong loss code");
    alarm_hold_a: assert property (O_CTRL.alarm_stop && I_RESET_CONTACT
        |=> O_CTRL.alarm_stop)
        else $error("alarm cleared while contact closed");
    quiet_code_a: assert property (!O_CTRL.alarm_stop |->
        O_CTRL.led_code == CODE_NONE && !O_CTRL.disconnect_msg)
        else $error("indication without alarm");
    bus_ok_a: assert property (O_HREADYOUT && !O_HRESP)
        else $error("bus not ready or error");
    cover property (I_STOP_KEY && !I_KEYPAD_MODE && O_CTRL.decel_stop);
    cover property ($rose(I_KEYPAD_PRESENT) && seen_q);
    cover property ($fell(I_RESET_CONTACT));
endmodule
`default_nettype wire

/* File: sim/pls_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module pls_top_test;
    import pls_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        mode = 1'b0;
    logic        ex;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic [4:0]  sels [8] = '{5'h0, 5'h1, 5'h2, 5'h3,
                              5'he, 5'hf, 5'h10, 5'h11};
    wire logic   hready, hresp, irq, present, legacy, stop_key, contact;
    wire logic [31:0] hrdata;
    wire pls_out_s    ctrl;
    int          fails = 0;
    int          n_compared = 0;
    int          cyc = 0;
    pls_top dut_u (
        .I_CLK(clk), .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
        .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp),
        .I_KEYPAD_PRESENT(present), .I_KEYPAD_LEGACY(legacy),
        .I_STOP_KEY(stop_key), .I_KEYPAD_MODE(mode),
        .I_RESET_CONTACT(contact), .O_CTRL(ctrl), .O_IRQ(irq));
    pls_keypad kp_u (
        .i_clk(clk), .o_present(present), .o_legacy(legacy),
        .o_stop_key(stop_key), .o_contact(contact));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic exp_decel(input logic [4:0] s, input logic m);
        return s >= 5'h0e || m;
    endfunction
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 40);
        rd = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'ha56bd8a9));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", 32'h0e, rd);
        bus(1'b0, ADDR_IRQ_MASK, 32'h0);
        chk("mask", 32'h0, rd);
        bus(1'b1, 8'h10, $urandom());
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        foreach (sels[i]) begin
            for (int m = 0; m < 2; m++) begin
                mode <= m[0];
                bus(1'b1, ADDR_CTRL, {27'h0, sels[i]});
                kp_u.set_stop(1'b1);
                repeat (3) @(posedge clk);
                ex = exp_decel(sels[i], m[0]);
                chk("decel", 32'(ex), 32'(ctrl.decel_stop));
                kp_u.set_stop(1'b0);
                repeat (2) @(posedge clk);
            end
        end
        bus(1'b1, ADDR_IRQ_STAT, 32'h7);
        bus(1'b1, ADDR_IRQ_MASK, 32'h2);
        kp_u.set_stop(1'b1);
        repeat (3) @(posedge clk);
        kp_u.set_stop(1'b0);
        repeat (3) @(posedge clk);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("irq_stat", 32'h2, rd);
        chk("irq_on", 32'h1, 32'(irq));
        bus(1'b1, ADDR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq_masked", 32'h0, 32'(irq));
        bus(1'b1, ADDR_IRQ_STAT, 32'h2);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("irq_clear", 32'h0, rd);
        bus(1'b1, ADDR_CTRL, 32'h10);
        kp_u.unplug($urandom_range(500, 5));
        repeat (3) @(posedge clk);
        chk("alarm", 32'h0, 32'(ctrl.alarm_stop));
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h1, rd & 32'h83);
        bus(1'b1, ADDR_CTRL, 32'h0);
        kp_u.tap_reset($urandom_range(200, 20));
        repeat (3) @(posedge clk);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("short_events", 32'h0, rd & 32'h5);
        close_out();
    end
endmodule
bind pls_top pls_props chk_u (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
    .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA),
    .I_HREADY(I_HREADY), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
    .I_KEYPAD_PRESENT(I_KEYPAD_PRESENT), .I_KEYPAD_LEGACY(I_KEYPAD_LEGACY),
    .I_STOP_KEY(I_STOP_KEY), .I_KEYPAD_MODE(I_KEYPAD_MODE),
    .I_RESET_CONTACT(I_RESET_CONTACT), .O_CTRL(O_CTRL));
`default_nettype wire

/* File: verilog/pls_pkg.sv */
package pls_pkg;

    // Clock and timing.
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned LOSS_TIME_MS     = 1000;
    localparam int unsigned LOSS_CYCLES      = CLK_HZ / 1000 * LOSS_TIME_MS;
    localparam int unsigned RST_CONTACT_MS   = 100;
    localparam int unsigned RST_CYCLES       = CLK_HZ / 1000 * RST_CONTACT_MS;
    localparam int unsigned CNT_W            = 24;

    // Register map, byte addresses.
    localparam logic [7:0] ADDR_CTRL         = 8'h00;
    localparam logic [7:0] ADDR_STATUS       = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT     = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h0c;

    // Control field positions and reset values.
    localparam int unsigned CTRL_SEL_LSB     = 0;
    localparam int unsigned CTRL_SEL_W       = 5;
    localparam logic [4:0]  SEL_RESET_VAL    = 5'h0e;
    localparam int unsigned CTRL_PROT_BIT    = 8;

    // Interrupt status bit positions.
    localparam int unsigned IRQ_LOSS_BIT     = 0;
    localparam int unsigned IRQ_STOP_BIT     = 1;
    localparam int unsigned IRQ_RESET_BIT    = 2;
    localparam int unsigned IRQ_W            = 3;

    // Indicator codes.
    localparam logic [1:0] CODE_NONE         = 2'h0;
    localparam logic [1:0] KEYPAD_LOSS_CODE  = 2'h1;
    localparam logic [1:0] LEGACY_LOSS_CODE  = 2'h2;

    // AHB-Lite encodings.
    localparam logic [1:0] HTRANS_NONSEQ     = 2'h2;

    typedef enum logic [1:0] {
        PLS_ST_INIT  = 2'b00,
        PLS_ST_RUN   = 2'b01,
        PLS_ST_ALARM = 2'b10
    } pls_state_e;

    typedef struct packed {
        logic       alarm_stop;
        logic       output_off;
        logic       decel_stop;
        logic       disconnect_msg;
        logic [1:0] led_code;
    } pls_out_s;

endpackage

/* File: verilog/pls_top.sv */
// Behaviour
// - With loss detection selected, a missing keypad switches both displays to the loss error and enters alarm stop.
// - Selections 0, 2, 14 and 16 accept the reset input at any time.
// - Selections 1, 3, 15 and 17 accept the reset input only while a protective trip is active.
// - Selections 0, 1, 14 and 15 keep running after keypad removal with no alarm.
// - Selections 2, 3, 16 and 17 show an error and shut off the output once removal is detected.
// - Selections 0 to 3 make the stop key decelerate to a stop only in keypad operation mode.
// - Selections 14 to 17 make the stop key decelerate to a stop in every mode.
// - The keypad counts as lost only after more than one second of continuous absence.
// - A keypad already absent at start-up raises no loss alarm.
// - A loss alarm shows the disconnect message on the keypad and the keypad loss code on the indicator.
// - With the older keypad model the alarm shows the legacy loss code instead.
// - Shorting the reset terminal to common for more than 0.1 s and releasing it is a reset request.
`timescale 1ns/10ps
`default_nettype none
module pls_top
    import pls_pkg::*;
(
    // Clock and reset.
    input  wire logic                 I_CLK,
    input  wire logic                 I_RSTN,
    // AHB-Lite slave.
    input  wire logic                 I_HSEL,
    input  wire logic [7:0]           I_HADDR,
    input  wire logic [1:0]           I_HTRANS,
    input  wire logic                 I_HWRITE,
    input  wire logic [2:0]           I_HSIZE,
    input  wire logic [31:0]          I_HWDATA,
    input  wire logic                 I_HREADY,
    output logic [31:0]               O_HRDATA,
    output logic                      O_HREADYOUT,
    output logic                      O_HRESP,
    // Keypad and contacts.
    input  wire logic                 I_KEYPAD_PRESENT,
    input  wire logic                 I_KEYPAD_LEGACY,
    input  wire logic                 I_STOP_KEY,
    input  wire logic                 I_KEYPAD_MODE,
    input  wire logic                 I_RESET_CONTACT,
    // Drive control outputs.
    output pls_pkg::pls_out_s         O_CTRL,
    output logic                      O_IRQ
);
    import pls_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [4:0]       sel_q;
    logic             prot_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic             wr_pend_q;
    logic [7:0]       wr_addr_q;
    logic             rd_pend_q;
    logic [7:0]       rd_addr_q;
    logic [31:0]      rdata_q;
    logic             addr_ok;
    logic             w1c_stat;

    assign addr_ok  = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ);
    assign w1c_stat = wr_pend_q && (wr_addr_q == ADDR_IRQ_STAT);

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rd_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok && I_HWRITE;
            rd_pend_q <= addr_ok && !I_HWRITE;
            if (addr_ok) begin
                wr_addr_q <= I_HADDR;
                rd_addr_q <= I_HADDR;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            sel_q      <= SEL_RESET_VAL;
            prot_q     <= 1'b0;
            irq_mask_q <= '0;
        end else if (wr_pend_q) begin
            if (wr_addr_q == ADDR_CTRL) begin
                sel_q  <= I_HWDATA[CTRL_SEL_LSB +: CTRL_SEL_W];
                prot_q <= I_HWDATA[CTRL_PROT_BIT];
            end
            if (wr_addr_q == ADDR_IRQ_MASK) begin
                irq_mask_q <= I_HWDATA[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Selection decode; unlisted codes get no loss detection, reset by bit 0, and stop in every mode only from 18 up.
    logic sel_any_reset;
    logic sel_loss_det;
    logic sel_stop_all;

    always_comb begin
        sel_any_reset = ~sel_q[0];
        sel_loss_det  = (sel_q[4:1] == 4'h1)
                        || (sel_q[4:1] == 4'h8);
        sel_stop_all  = (sel_q >= 5'h0e);
    end

    ////////////////////////////////////////////////////////////////////////
    // Keypad absence filter.
    logic [CNT_W-1:0] abs_cnt_q;
    logic             lost_q;
    logic             seen_q;

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            abs_cnt_q <= '0;
            lost_q    <= 1'b0;
        end else if (I_KEYPAD_PRESENT) begin
            abs_cnt_q <= '0;
            lost_q    <= 1'b0;
        end else if (abs_cnt_q < CNT_W'(LOSS_CYCLES)) begin
            abs_cnt_q <= abs_cnt_q + 1'b1;
        end else begin
            lost_q    <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            seen_q <= 1'b0;
        end else if (I_KEYPAD_PRESENT) begin
            seen_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset contact: closure longer than 0.1 s, then release.
    logic [CNT_W-1:0] rc_cnt_q;
    logic             rc_req;

    assign rc_req = !I_RESET_CONTACT && (rc_cnt_q > CNT_W'(RST_CYCLES));

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            rc_cnt_q <= '0;
        end else if (!I_RESET_CONTACT) begin
            rc_cnt_q <= '0;
        end else if (rc_cnt_q <= CNT_W'(RST_CYCLES)) begin
            rc_cnt_q <= rc_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    pls_state_e state_q;
    logic       trip_active;
    logic       reset_ok;
    logic       loss_event;
    logic [1:0] code_q;

    assign trip_active = (state_q == PLS_ST_ALARM) || prot_q;
    assign reset_ok    = rc_req && (sel_any_reset || trip_active);
    assign loss_event  = lost_q && seen_q && sel_loss_det
                         && (state_q == PLS_ST_RUN);

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            state_q <= PLS_ST_INIT;
            code_q  <= CODE_NONE;
        end else begin
            unique case (state_q)
                PLS_ST_INIT: begin
                    state_q <= PLS_ST_RUN;
                end
                PLS_ST_RUN: begin
                    if (loss_event) begin
                        state_q <= PLS_ST_ALARM;
                        code_q  <= I_KEYPAD_LEGACY ? LEGACY_LOSS_CODE
                                                   : KEYPAD_LOSS_CODE;
                    end
                end
                PLS_ST_ALARM: begin
                    if (reset_ok) begin
                        state_q <= PLS_ST_RUN;
                        code_q  <= CODE_NONE;
                    end
                end
                default: begin
                    state_q <= PLS_ST_INIT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic stop_req;

    assign stop_req = I_STOP_KEY && (sel_stop_all || I_KEYPAD_MODE);

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            O_CTRL <= '0;
        end else begin
            // All indications follow the state so they rise together.
            O_CTRL.alarm_stop     <= (state_q == PLS_ST_ALARM);
            O_CTRL.output_off     <= (state_q == PLS_ST_ALARM);
            O_CTRL.disconnect_msg <= (state_q == PLS_ST_ALARM)
                                     && (code_q != CODE_NONE);
            O_CTRL.led_code       <= code_q;
            O_CTRL.decel_stop     <= stop_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events; a set in the same cycle as a clear wins.
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;

    assign ev[IRQ_LOSS_BIT]  = loss_event;
    assign ev[IRQ_STOP_BIT]  = stop_req;
    assign ev[IRQ_RESET_BIT] = reset_ok;
    assign clr = w1c_stat ? I_HWDATA[IRQ_W-1:0] : '0;

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            irq_stat_q <= '0;
            O_IRQ      <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~clr) | ev;
            O_IRQ      <= |(irq_stat_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            rdata_q <= '0;
        end else if (addr_ok && !I_HWRITE) begin
            unique case (I_HADDR)
                ADDR_CTRL:     rdata_q <= {23'h0, prot_q, 3'h0, sel_q};
                ADDR_STATUS:   rdata_q <= {24'h0, lost_q, seen_q,
                                           code_q, 2'h0, state_q};
                ADDR_IRQ_STAT: rdata_q <= {29'h0, irq_stat_q};
                ADDR_IRQ_MASK: rdata_q <= {29'h0, irq_mask_q};
                default:       rdata_q <= '0;
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
        end else begin
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
        end
    end

    assign O_HRDATA = rdata_q;

endmodule
`default_nettype wire
